/* File: core/scrl_pkg.sv */
// Constants and types shared by the slope counter readout logic.
`default_nettype none
package scrl_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int QUANTUM_NS = 1000;
   localparam int QUANTUM_CYC = (QUANTUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIGITS = 4;
   localparam int BCD_W = 4;
   localparam int CNT_W = DIGITS * BCD_W;
   localparam int SEG_W = 7;
   localparam int RANGE_W = 3;
   localparam int GAP_W = 8;
   localparam logic [GAP_W-1:0] GAP_TICKS = 8'h64;
   localparam logic [BCD_W-1:0] BCD_MAX = 4'h9;
   localparam logic [BCD_W-1:0] BCD_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_FULL = 16'h9999;
   localparam logic [DIGITS-1:0] DP_NONE = 4'h0;
   localparam logic [BCD_W-1:0] FUNC_VOLT_CODE = 4'h0;
   localparam logic [BCD_W-1:0] FUNC_AMP_CODE = 4'h1;
   localparam logic [BCD_W-1:0] POL_POS_CODE = 4'h0;
   localparam logic [BCD_W-1:0] POL_NEG_CODE = 4'h1;
   // Synchroniser vector bit positions.
   localparam int SY_CMP = 0;
   localparam int SY_HOLD = 1;
   localparam int SY_POL = 2;
   localparam int SY_REQ = 3;
   localparam int SY_ACK = 4;
   localparam int SY_SWA = 5;
   localparam int SY_SWB = 6;
   localparam int SY_SWC = 7;
   localparam int SY_SWD = 8;
   localparam int SY_W = 9;
   // Idle levels: hold terminal open (high), all others low.
   localparam logic [SY_W-1:0] SY_RESET = 9'h002;
   // Decimal point position for each range, voltage function then current function.
   localparam logic [8*DIGITS-1:0] DP_VOLT_TAB = 32'h84218421;
   localparam logic [8*DIGITS-1:0] DP_AMP_TAB = 32'h42184218;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_INTEG = 2'b01,
      ST_DEINT = 2'b10
   } scrl_state_e;
endpackage
`default_nettype wire

/* File: core/scrl_readout.sv */
// Readout, buffer store, display decode and system interface of the slope counter.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1 - Comparator is resynchronised to the clock before any count is read.
// RULE2 - A flip-flop samples the comparator once per elementary clock period.
// RULE3 - After a late trip the counter advances once more, then the store captures.
// RULE4 - A deintegration that overruns the full count captures with an overload flag.
// RULE5 - The buffer store holds the result as four BCD digits.
// RULE6 - Buffered digits drive the segment decoder and the parallel output together; the registered segments follow one clock after the parallel output.
// RULE7 - Each buffered digit is decoded into seven segment drive lines.
// RULE8 - Decimal point position is decoded from selected range and function.
// RULE9 - Display shows polarity and an indicator lasting each measuring cycle.
// RULE10 - During hold the last value is kept indefinitely.
// RULE11 - The outside party requests hold by pulling the hold terminal low.
// RULE12 - A high hold terminal cancels hold and updating resumes.
// RULE13 - Four switches select recording mode; four coupling signals handshake.
// RULE14 - Range, function and polarity are presented as 8421 BCD codes.
// RULE15 - Integration and deintegration are timed in elementary clock periods.
// RULE16 - Integration always lasts the counter's full count.
// RULE17 - The counter is cleared at the start of each deintegration.
// RULE18 - Hold suppresses every capture while measuring cycles continue.
module scrl_readout #(
   parameter int QUANTUM_CYCLES = scrl_pkg::QUANTUM_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic comparator_trip,
   input wire logic hold_n,
   input wire logic input_negative,
   input wire logic [scrl_pkg::RANGE_W-1:0] range_sel,
   input wire logic function_current,
   input wire logic record_mode_switch_a,
   input wire logic record_mode_switch_b,
   input wire logic record_mode_switch_c,
   input wire logic record_mode_switch_d,
   input wire logic coupling_signal_first,
   input wire logic coupling_signal_second,
   output logic coupling_signal_third,
   output logic coupling_signal_fourth,
   output logic integrate_en,
   output logic deintegrate_en,
   output logic [scrl_pkg::CNT_W-1:0] result_bcd,
   output logic [scrl_pkg::DIGITS*scrl_pkg::SEG_W-1:0] segments,
   output logic [scrl_pkg::DIGITS-1:0] decimal_point,
   output logic polarity_negative,
   output logic cycle_indicator,
   output logic overload,
   output logic [scrl_pkg::BCD_W-1:0] range_code,
   output logic [scrl_pkg::BCD_W-1:0] function_code,
   output logic [scrl_pkg::BCD_W-1:0] polarity_code
);

   // BCD increment of the whole counter, carry out on top.
   function automatic logic [scrl_pkg::CNT_W:0] bcd_inc(input logic [scrl_pkg::CNT_W-1:0] v);
      logic [scrl_pkg::CNT_W-1:0] r;
      logic c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < scrl_pkg::DIGITS; i++) begin
         if (c) begin
            if (v[i*scrl_pkg::BCD_W +: scrl_pkg::BCD_W] == scrl_pkg::BCD_MAX) begin
               r[i*scrl_pkg::BCD_W +: scrl_pkg::BCD_W] = scrl_pkg::BCD_ZERO;
            end else begin
               r[i*scrl_pkg::BCD_W +: scrl_pkg::BCD_W] = v[i*scrl_pkg::BCD_W +: scrl_pkg::BCD_W] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return {c, r};
   endfunction

   // BCD digit to segments g..a, active high.
   function automatic logic [scrl_pkg::SEG_W-1:0] seg7(input logic [scrl_pkg::BCD_W-1:0] d);
      logic [scrl_pkg::SEG_W-1:0] s;
      s = 7'h00;
      case (d)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         default: s = 7'h40;
      endcase
      return s;
   endfunction

   logic [scrl_pkg::SY_W-1:0] sy1_q, sy2_q, sy3_q, syf_q, syf_d;
   scrl_pkg::scrl_state_e state_q;
   logic [31:0] div_q;
   logic tick;
   logic [scrl_pkg::CNT_W-1:0] count_q;
   logic [scrl_pkg::CNT_W:0] count_inc;
   logic [scrl_pkg::GAP_W-1:0] gap_q;
   logic cmp_sample_q;
   logic cap_evt, ovf_evt, rec_evt, hold_active, start_ok;
   logic req_prev_q, armed_q, ack_prev_q;
   logic [scrl_pkg::CNT_W-1:0] digits_q;
   logic [scrl_pkg::DIGITS-1:0] dp_row;

   // Three-stage synchroniser; a level is accepted once stages two and three agree.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sy1_q <= scrl_pkg::SY_RESET;
         sy2_q <= scrl_pkg::SY_RESET;
         sy3_q <= scrl_pkg::SY_RESET;
      end else begin
         sy1_q <= {record_mode_switch_d, record_mode_switch_c, record_mode_switch_b, record_mode_switch_a,
                   coupling_signal_second, coupling_signal_first, input_negative, hold_n, comparator_trip};
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
      end
   end

   assign syf_d = (sy2_q & ~(sy2_q ^ sy3_q)) | (syf_q & (sy2_q ^ sy3_q));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         syf_q <= scrl_pkg::SY_RESET;
      end else begin
         syf_q <= syf_d; // RULE1
      end
   end

   // Hold is active while the terminal is low; a high level releases it.
   assign hold_active = ~syf_q[scrl_pkg::SY_HOLD]; // RULE11 RULE12

   // Elementary clock period divider.
   always_ff @(posedge clk) begin
      if (sys_rst || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 32'h1;
      end
   end

   assign tick = (div_q >= 32'(QUANTUM_CYCLES - 1)); // RULE15

   assign count_inc = bcd_inc(count_q);

   // Comparator sampled by a flip-flop once per elementary period.
   always_ff @(posedge clk) begin
      if (sys_rst || state_q != scrl_pkg::ST_DEINT) begin
         cmp_sample_q <= 1'b0;
      end else if (tick) begin
         cmp_sample_q <= syf_q[scrl_pkg::SY_CMP]; // RULE2
      end
   end

   // Capture one period after the sampled trip, so the count has advanced once more.
   assign cap_evt = (state_q == scrl_pkg::ST_DEINT) && tick && (cmp_sample_q || count_inc[scrl_pkg::CNT_W]); // RULE3
   assign ovf_evt = (state_q == scrl_pkg::ST_DEINT) && tick && !cmp_sample_q && count_inc[scrl_pkg::CNT_W]; // RULE4

   assign start_ok = (gap_q == scrl_pkg::GAP_TICKS) && (!syf_q[scrl_pkg::SY_SWD] || syf_q[scrl_pkg::SY_REQ]);

   // Measuring sequence: pause, integrate for the full count, deintegrate until trip or overrun.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= scrl_pkg::ST_WAIT;
         count_q <= scrl_pkg::CNT_ZERO;
         gap_q <= '0;
      end else if (tick) begin
         unique case (state_q)
            scrl_pkg::ST_WAIT: begin
               count_q <= scrl_pkg::CNT_ZERO;
               if (gap_q != scrl_pkg::GAP_TICKS) begin
                  gap_q <= gap_q + 8'h01;
               end else if (start_ok) begin
                  state_q <= scrl_pkg::ST_INTEG;
               end
            end
            scrl_pkg::ST_INTEG: begin
               if (count_q == scrl_pkg::CNT_FULL) begin // RULE16
                  count_q <= scrl_pkg::CNT_ZERO; // RULE17
                  state_q <= scrl_pkg::ST_DEINT;
               end else begin
                  count_q <= count_inc[scrl_pkg::CNT_W-1:0]; // RULE15
               end
            end
            scrl_pkg::ST_DEINT: begin
               if (cap_evt) begin
                  state_q <= scrl_pkg::ST_WAIT;
                  gap_q <= '0;
               end else begin
                  count_q <= count_inc[scrl_pkg::CNT_W-1:0]; // RULE15
               end
            end
            default: begin
               state_q <= scrl_pkg::ST_WAIT;
            end
         endcase
      end
   end

   assign integrate_en = (state_q == scrl_pkg::ST_INTEG);
   assign deintegrate_en = (state_q == scrl_pkg::ST_DEINT);
   assign cycle_indicator = (state_q != scrl_pkg::ST_WAIT); // RULE9

   // Buffer store; hold blocks capture and keeps the value.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         digits_q <= scrl_pkg::CNT_ZERO;
         overload <= 1'b0;
         polarity_negative <= 1'b0;
      end else if (cap_evt && !hold_active) begin // RULE10 RULE18
         digits_q <= ovf_evt ? scrl_pkg::CNT_FULL : count_q; // RULE5
         overload <= ovf_evt; // RULE4
         polarity_negative <= syf_q[scrl_pkg::SY_POL]; // RULE9
      end
   end

   assign result_bcd = digits_q; // RULE6

   // Segment, decimal point and code outputs.
   assign dp_row = function_current ? scrl_pkg::DP_AMP_TAB[range_sel*scrl_pkg::DIGITS +: scrl_pkg::DIGITS] :
                   scrl_pkg::DP_VOLT_TAB[range_sel*scrl_pkg::DIGITS +: scrl_pkg::DIGITS];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         segments <= '0;
         decimal_point <= scrl_pkg::DP_NONE;
      end else begin
         for (int i = 0; i < scrl_pkg::DIGITS; i++) begin
            segments[i*scrl_pkg::SEG_W +: scrl_pkg::SEG_W] <= seg7(digits_q[i*scrl_pkg::BCD_W +: scrl_pkg::BCD_W]); // RULE7
         end
         decimal_point <= dp_row; // RULE8
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         range_code <= scrl_pkg::BCD_ZERO;
         function_code <= scrl_pkg::FUNC_VOLT_CODE;
         polarity_code <= scrl_pkg::POL_POS_CODE;
      end else begin
         range_code <= {1'b0, range_sel}; // RULE14
         function_code <= function_current ? scrl_pkg::FUNC_AMP_CODE : scrl_pkg::FUNC_VOLT_CODE; // RULE14
         polarity_code <= polarity_negative ? scrl_pkg::POL_NEG_CODE : scrl_pkg::POL_POS_CODE; // RULE14
      end
   end

   // System interface recording: one-shot, cyclic or conditional.
   assign rec_evt = cap_evt && !hold_active && syf_q[scrl_pkg::SY_SWA] &&
                    (syf_q[scrl_pkg::SY_SWB] || (syf_q[scrl_pkg::SY_SWC] ? syf_q[scrl_pkg::SY_REQ] : armed_q)); // RULE13

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         req_prev_q <= 1'b0;
         ack_prev_q <= 1'b0;
         armed_q <= 1'b0;
         coupling_signal_third <= 1'b0;
      end else begin
         req_prev_q <= syf_q[scrl_pkg::SY_REQ];
         ack_prev_q <= syf_q[scrl_pkg::SY_ACK];
         if (syf_q[scrl_pkg::SY_REQ] && !req_prev_q) begin
            armed_q <= 1'b1;
         end else if (rec_evt) begin
            armed_q <= 1'b0;
         end
         if (rec_evt) begin
            coupling_signal_third <= 1'b1; // RULE13
         end else if (syf_q[scrl_pkg::SY_ACK] && !ack_prev_q) begin
            coupling_signal_third <= 1'b0;
         end
      end
   end

   assign coupling_signal_fourth = cycle_indicator; // RULE13

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_integ_end;
      state_q == scrl_pkg::ST_INTEG && tick && count_q == scrl_pkg::CNT_FULL;
   endsequence
   sequence s_deint_start;
      state_q == scrl_pkg::ST_DEINT && count_q == scrl_pkg::CNT_ZERO;
   endsequence

   property p_capture_synced;
      cap_evt && !ovf_evt |-> $past(syf_q[scrl_pkg::SY_CMP], QUANTUM_CYCLES);
   endproperty
   a_capture_synced: assert property (p_capture_synced) else $error("Capture without a sampled trip."); // RULE1

   property p_sample_on_tick;
      state_q == scrl_pkg::ST_DEINT && !tick |=> $stable(cmp_sample_q);
   endproperty
   a_sample_on_tick: assert property (p_sample_on_tick) else $error("Comparator sampled off the period edge."); // RULE2

   property p_integ_to_deint;
      s_integ_end |=> s_deint_start;
   endproperty
   a_integ_to_deint: assert property (p_integ_to_deint) else $error("Integration end or counter clear wrong."); // RULE16

   property p_overload;
      ovf_evt && !hold_active |=> overload && result_bcd == scrl_pkg::CNT_FULL;
   endproperty
   a_overload: assert property (p_overload) else $error("Overrun did not flag overload."); // RULE4

   property p_store_takes_count;
      cap_evt && !ovf_evt && !hold_active |=> result_bcd == $past(count_q) && !overload;
   endproperty
   a_store_takes_count: assert property (p_store_takes_count) else $error("Store did not take the count."); // RULE5

   property p_hold_keeps;
      hold_active |=> $stable(result_bcd);
   endproperty
   a_hold_keeps: assert property (p_hold_keeps) else $error("Value changed during hold."); // RULE10

   property p_hold_no_record;
      hold_active |-> !rec_evt ##1 !$rose(coupling_signal_third);
   endproperty
   a_hold_no_record: assert property (p_hold_no_record) else $error("Record during hold."); // RULE18

   property p_segments_follow;
      $changed(result_bcd) |=> segments[scrl_pkg::SEG_W-1:0] == seg7(result_bcd[scrl_pkg::BCD_W-1:0]);
   endproperty
   a_segments_follow: assert property (p_segments_follow) else $error("Segments lag the store."); // RULE7

   property p_ready_from_record;
      $rose(coupling_signal_third) |-> $past(rec_evt);
   endproperty
   a_ready_from_record: assert property (p_ready_from_record) else $error("Data ready without a record."); // RULE13

   property p_codes_bcd;
      ##1 range_code <= scrl_pkg::BCD_MAX && function_code <= scrl_pkg::FUNC_AMP_CODE;
   endproperty
   a_codes_bcd: assert property (p_codes_bcd) else $error("Code outside 8421 range."); // RULE14

endmodule

`default_nettype wire

/* File: bench/scrl_far_model.sv */
// Far-side model: analogue comparator and system interface acknowledge.
`timescale 1ns/1ps
`default_nettype none
module scrl_far_model (
   input wire logic clk,
   input wire logic deintegrate_en,
   input wire logic coupling_signal_third,
   input wire logic [31:0] trip_after,
   input wire logic [31:0] ack_delay,
   output logic comparator_trip,
   output logic coupling_signal_second
);
   int deint_cnt = 0;
   int ack_cnt = 0;
   initial begin
      comparator_trip = 1'b0;
      coupling_signal_second = 1'b0;
   end
   // The comparator trips after trip_after clocks of deintegration and stays tripped until it ends.
   always @(negedge clk) begin
      deint_cnt = deintegrate_en ? deint_cnt + 1 : 0;
      comparator_trip <= deintegrate_en && (deint_cnt > trip_after);
      ack_cnt = coupling_signal_third ? ack_cnt + 1 : 0;
      coupling_signal_second <= coupling_signal_third && (ack_cnt > ack_delay);
   end
endmodule
`default_nettype wire

/* File: bench/test_slope_counter_readout_logic.sv */
// Self-checking bench for the slope counter readout logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module test_slope_counter_readout_logic;
   localparam int Q = 1;
   localparam int LIMIT = 95000;
   localparam logic [6:0] SEG [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hold_n = 1'b1;
   logic input_negative = 1'b0;
   logic [2:0] range_sel = 3'h0;
   logic function_current = 1'b0;
   logic sw_a = 1'b1;
   logic sw_b = 1'b1;
   logic sw_c = 1'b0;
   logic sw_d = 1'b0;
   logic first = 1'b0;
   logic comparator_trip, second, third, fourth, integrate_en, deintegrate_en;
   logic polarity_negative, cycle_indicator, overload;
   logic [15:0] result_bcd;
   logic [27:0] segments;
   logic [3:0] decimal_point, range_code, function_code, polarity_code;
   logic [31:0] trip_after = 32'h0;
   logic [31:0] seed = 32'h5192EDDC;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   int r1, r2, r3;

   always #25 clk = ~clk;

   scrl_readout #(.QUANTUM_CYCLES(Q)) dut_u (.clk(clk), .sys_rst(sys_rst), .comparator_trip(comparator_trip),
      .hold_n(hold_n), .input_negative(input_negative), .range_sel(range_sel), .function_current(function_current),
      .record_mode_switch_a(sw_a), .record_mode_switch_b(sw_b), .record_mode_switch_c(sw_c),
      .record_mode_switch_d(sw_d), .coupling_signal_first(first), .coupling_signal_second(second),
      .coupling_signal_third(third), .coupling_signal_fourth(fourth), .integrate_en(integrate_en),
      .deintegrate_en(deintegrate_en), .result_bcd(result_bcd), .segments(segments),
      .decimal_point(decimal_point), .polarity_negative(polarity_negative), .cycle_indicator(cycle_indicator),
      .overload(overload), .range_code(range_code), .function_code(function_code), .polarity_code(polarity_code));

   scrl_far_model far_u (.clk(clk), .deintegrate_en(deintegrate_en), .coupling_signal_third(third),
      .trip_after(trip_after), .ack_delay(32'hA), .comparator_trip(comparator_trip), .coupling_signal_second(second));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check_codes;
      logic [31:0] tab;
      tab = function_current ? scrl_pkg::DP_AMP_TAB : scrl_pkg::DP_VOLT_TAB;
      `CHK("decimal point", tab[4*range_sel +: 4], decimal_point);
      `CHK("range code", {1'b0, range_sel}, range_code);
      `CHK("function code", function_current ? scrl_pkg::FUNC_AMP_CODE : scrl_pkg::FUNC_VOLT_CODE, function_code);
   endtask

   // Runs one measuring cycle with the given comparator delay and checks the stored result.
   task automatic measure(input int target, input logic neg, input logic rec, output int res);
      int n;
      n = 0;
      trip_after = target;
      input_negative = neg;
      seed = xs(seed);
      range_sel = seed[2:0];
      function_current = seed[3];
      while (!integrate_en && n < 2000) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (integrate_en && n < 30000) begin
         @(negedge clk);
         n++;
      end
      `CHK("integration clocks", 10000 * Q, n);
      n = 0;
      while (deintegrate_en && n < 30000) begin
         @(negedge clk);
         n++;
      end
      repeat (4) @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         `CHK("digit is bcd", 1'b1, result_bcd[4*i +: 4] <= 4'h9);
         `CHK("segments", SEG[result_bcd[4*i +: 4]], segments[7*i +: 7]);
      end
      check_codes();
      `CHK("data ready", rec, third);
      res = result_bcd[15:12] * 1000 + result_bcd[11:8] * 100 + result_bcd[7:4] * 10 + result_bcd[3:0];
      repeat (30) @(negedge clk);
      `CHK("acknowledge clears", 1'b0, third);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         conclude();
      end
   end

   always @(negedge clk) begin
      if (!sys_rst) begin
         `CHK("cycle indicator", integrate_en | deintegrate_en, cycle_indicator);
         `CHK("busy signal", cycle_indicator, fourth);
      end
   end

   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         range_sel = i[2:0];
         function_current = i[3];
         repeat (2) @(negedge clk);
         check_codes();
      end
      measure(1234, 1'b0, 1'b1, r1);
      `CHK("result window", 1'b1, r1 >= 1234 && r1 <= 1240);
      `CHK("overload", 1'b0, overload);
      `CHK("polarity", 1'b0, polarity_negative);
      `CHK("polarity code", scrl_pkg::POL_POS_CODE, polarity_code);
      measure(5678, 1'b1, 1'b1, r2);
      `CHK("count difference", 5678 - 1234, r2 - r1);
      `CHK("polarity", 1'b1, polarity_negative);
      `CHK("polarity code", scrl_pkg::POL_NEG_CODE, polarity_code);
      hold_n = 1'b0;
      measure(42, 1'b0, 1'b0, r3);
      `CHK("held result", r2, r3);
      `CHK("held polarity", 1'b1, polarity_negative);
      hold_n = 1'b1;
      sw_b = 1'b0;
      sw_c = 1'b1;
      first = 1'b1;
      measure(9, 1'b0, 1'b1, r3);
      `CHK("resumed result", 9 - 1234, r3 - r1);
      first = 1'b0;
      measure(20000, 1'b0, 1'b0, r3);
      `CHK("overload result", scrl_pkg::CNT_FULL, result_bcd);
      `CHK("overload flag", 1'b1, overload);
      sw_a = 1'b0;
      sw_d = 1'b1;
      repeat (400) @(negedge clk);
      `CHK("start held off", 1'b0, integrate_en);
      first = 1'b1;
      measure(3, 1'b0, 1'b0, r3);
      `CHK("overload cleared", 1'b0, overload);
      sw_a = 1'b1;
      sw_c = 1'b0;
      measure(7, 1'b0, 1'b1, r3);
      `CHK("one-shot result", 7 - 1234, r3 - r1);
      conclude();
   end
endmodule
`default_nettype wire
